// file: rtl/psm_mouse_host.sv
`include "psm_defs.svh"

// Operation
// - The link is one clock line and one data line, each driven open-drain by both ends.
// - Each character is a zero start bit, eight data bits LSB first, odd parity, stop one.
// - Incoming data is sampled on each falling edge of the mouse clock.
// - A 33-bit shift register takes one bit per sampled falling edge.
// - Link clock and data pass a two-flop synchroniser before any logic reads them.
// - A send starts by holding clock low longer than one link clock period.
// - Data is pulled low while clock is still low, then clock is released.
// - The rising edge from that release is the start bit's sampling point.
// - A send is 12 bits: start, eight data, odd parity, stop, and mouse acknowledge.
// - After parity the data line is released for stop and acknowledge.
module psm_mouse_host
    import psm_pkg::*;
#(
    parameter int INHIBIT_CYC = `PSM_INHIBIT_CYC,
    parameter int RXTO_CYC    = `PSM_RXTO_CYC
) (
    // System
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Link clock pin
    input  wire logic       linkClkIn,
    output logic            linkClkOut,
    output logic            linkClkOe,
    // Link data pin
    input  wire logic       linkDatIn,
    output logic            linkDatOut,
    output logic            linkDatOe,
    // Command to send
    input  wire psm_pkg::psm_byte_t cmdByte,
    input  wire logic       cmdValid,
    output logic            cmdReady,
    // Send result
    output logic            txDone,
    output logic            txAckOk,
    // Received packet
    output psm_pkg::psm_byte_t pktByte0,
    output psm_pkg::psm_byte_t pktByte1,
    output psm_pkg::psm_byte_t pktByte2,
    output logic            pktErr,
    output logic            pktValid,
    input  wire logic       pktReady
);
    import psm_pkg::*;

    logic [1:0]  clkSync_r;
    logic [1:0]  datSync_r;
    logic        clkPrev_r;
    logic        fallW;
    logic        riseW;
    logic [32:0] rxShift_r;
    logic [5:0]  rxCnt_r;
    logic [19:0] rxTo_r;
    logic        rxDoneW;
    logic [24:0] rxWordW;
    logic        bufReady;
    logic [24:0] bufData;
    logic        bufValid;
    psm_tx_state_t txState_r;
    logic [19:0] txCnt_r;
    logic [9:0]  txShift_r;
    logic [3:0]  txBit_r;
    logic [19:0] inhibLen_r;

    // Odd parity over a byte: bit is set when the byte has even ones
    function automatic logic oddPar(input logic [7:0] b);
        return ~^b;
    endfunction

    // Character check: start zero, odd parity over data+parity, stop one
    function automatic logic charBad(input logic [10:0] c);
        return c[0] || !c[10] || (oddPar(c[8:1]) != c[9]);
    endfunction

    // Two-flop synchroniser; stage 0 feeds only stage 1
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clkSync_r <= 2'b11;
            datSync_r <= 2'b11;
            clkPrev_r <= 1'b1;
        end else begin
            clkSync_r <= {clkSync_r[0], linkClkIn};
            datSync_r <= {datSync_r[0], linkDatIn};
            clkPrev_r <= clkSync_r[1];
        end
    end
    assign fallW = clkPrev_r && !clkSync_r[1];
    assign riseW = !clkPrev_r && clkSync_r[1];

    // Receive shifter; new bits enter at top so first bit ends at bit 0
    always_ff @(posedge clk) begin
        if (sys_rst || txState_r != PSM_IDLE || rxTo_r == RXTO_CYC[19:0]) begin
            rxShift_r <= '0;
            rxCnt_r   <= 6'h00;
        end else if (rxDoneW) begin
            rxCnt_r   <= 6'h00;
        end else if (fallW && rxCnt_r != `PSM_FRAME_BITS) begin
            // A full shifter waiting on the buffer must not shift past 33
            rxShift_r <= {datSync_r[1], rxShift_r[32:1]};
            rxCnt_r   <= rxCnt_r + 6'h01;
        end
    end
    // Stalled-frame watchdog; the link clock may stop mid-frame
    always_ff @(posedge clk) begin
        if (sys_rst || rxCnt_r == 6'h00 || fallW) begin
            rxTo_r <= `PSM_CNT_ZERO;
        end else begin
            rxTo_r <= rxTo_r + 20'h00001;
        end
    end
    // Packet complete; the buffer absorbs receiver stalls
    assign rxDoneW = rxCnt_r == `PSM_FRAME_BITS && bufReady;
    assign rxWordW = {charBad(rxShift_r[32:22]) || charBad(rxShift_r[21:11])
                          || charBad(rxShift_r[10:0]),
                      rxShift_r[30:23], rxShift_r[19:12], rxShift_r[8:1]};

    psm_skid_buf #(
        .WIDTH(25)
    ) u_buf (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inData   (rxWordW),
        .inValid  (rxCnt_r == `PSM_FRAME_BITS),
        .inReady  (bufReady),
        .outData  (bufData),
        .outValid (bufValid),
        .outReady (pktReady && pktValid)
    );

    // Packet outputs registered from the buffer head
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pktValid <= 1'b0;
            pktErr   <= 1'b0;
            pktByte0 <= 8'h00;
            pktByte1 <= 8'h00;
            pktByte2 <= 8'h00;
        end else begin
            pktValid <= bufValid && !(pktReady && pktValid);
            pktErr   <= bufData[24];
            pktByte2 <= bufData[23:16];
            pktByte1 <= bufData[15:8];
            pktByte0 <= bufData[7:0];
        end
    end

    // Send sequencer: inhibit, request, shift, release, acknowledge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txState_r  <= PSM_IDLE;
            txCnt_r    <= `PSM_CNT_ZERO;
            txShift_r  <= 10'h3ff;
            txBit_r    <= 4'h0;
            linkClkOe  <= 1'b0;
            linkDatOe  <= 1'b0;
            cmdReady   <= 1'b0;
            txDone     <= 1'b0;
            txAckOk    <= 1'b0;
        end else begin
            txDone   <= 1'b0;
            cmdReady <= 1'b0;
            txCnt_r  <= txCnt_r + 20'h00001;
            case (txState_r)
                PSM_IDLE: begin
                    if (cmdValid && !cmdReady) begin
                        // Aborts any frame under way
                        txShift_r <= {1'b1, oddPar(cmdByte), cmdByte};
                        cmdReady  <= 1'b1;
                        linkClkOe <= 1'b1;
                        txCnt_r   <= `PSM_CNT_ZERO;
                        txState_r <= PSM_INHIBIT;
                    end
                end
                PSM_INHIBIT: begin
                    if (txCnt_r == INHIBIT_CYC[19:0]) begin
                        linkDatOe <= 1'b1;
                        txCnt_r   <= `PSM_CNT_ZERO;
                        txState_r <= PSM_REQUEST;
                    end
                end
                PSM_REQUEST: begin
                    if (txCnt_r == 20'(`PSM_REQ_CYC)) begin
                        linkClkOe <= 1'b0;
                        txBit_r   <= 4'h0;
                        txState_r <= PSM_SHIFT;
                    end
                end
                PSM_SHIFT: begin
                    // Mouse clocks the bits; we only change data after its fall
                    if (fallW) begin
                        linkDatOe <= !txShift_r[0];
                        txShift_r <= {1'b1, txShift_r[9:1]};
                        txBit_r   <= txBit_r + 4'h1;
                        if (txBit_r == `PSM_PAR_IDX) begin
                            linkDatOe <= 1'b0;
                            txState_r <= PSM_RELEASE;
                        end
                    end
                end
                PSM_RELEASE: begin
                    // Stop bit clocked; ack bit follows
                    if (fallW) begin
                        txState_r <= PSM_ACK;
                    end
                end
                PSM_ACK: begin
                    if (fallW) begin
                        txAckOk   <= !datSync_r[1];
                        txDone    <= 1'b1;
                        txState_r <= PSM_IDLE;
                    end
                end
                default: txState_r <= PSM_IDLE;
            endcase
        end
    end
    // Open-drain: only ever drive low
    assign linkClkOut = 1'b0;
    assign linkDatOut = 1'b0;

    // Data stays released for at least 8 cycles after clock is pulled low for inhibit
    property inhibitHold;
        @(posedge clk) disable iff (sys_rst)
        $rose(linkClkOe) |-> !linkDatOe [*8];
    endproperty
    inhibit_hold_a: assert property (inhibitHold)
        else $error("data pulled during inhibit");

    sequence reqSeq;
        linkClkOe && linkDatOe;
    endsequence
    clk_release_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(linkClkOe) |-> linkDatOe)
        else $error("clock released without data low");

    data_change_a: assert property (@(posedge clk) disable iff (sys_rst)
        (txState_r == PSM_SHIFT && $changed(linkDatOe)) |-> $past(fallW))
        else $error("send bit changed off falling edge");

    release_data_a: assert property (@(posedge clk) disable iff (sys_rst)
        (txState_r == PSM_RELEASE || txState_r == PSM_ACK) |-> !linkDatOe)
        else $error("data held in stop or ack");

    no_clock_a: assert property (@(posedge clk) disable iff (sys_rst)
        txState_r == PSM_SHIFT |-> !linkClkOe)
        else $error("host drove clock while shifting");

    shift_count_a: assert property (@(posedge clk) disable iff (sys_rst)
        (fallW && txState_r == PSM_IDLE && rxCnt_r < `PSM_FRAME_BITS)
        |=> rxCnt_r == $past(rxCnt_r) + 6'h01 || rxCnt_r == 6'h00)
        else $error("receive count skipped");

    sample_data_a: assert property (@(posedge clk) disable iff (sys_rst)
        (fallW && txState_r == PSM_IDLE && rxCnt_r < `PSM_FRAME_BITS && rxTo_r != 20'hfffff)
        |=> rxShift_r[32] == $past(datSync_r[1]) || rxCnt_r == 6'h00)
        else $error("wrong bit sampled");

    // Even ones over data and parity, or a high start bit, must raise the flag
    err_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        (rxDoneW && (!(^rxShift_r[9:1]) || !(^rxShift_r[20:12]) || !(^rxShift_r[31:23])
            || rxShift_r[0] || rxShift_r[11] || rxShift_r[22])) |-> rxWordW[24])
        else $error("bad character not flagged");

    request_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(linkDatOe) && txState_r == PSM_REQUEST |-> reqSeq)
        else $error("request without clock held");

    // Inhibit length seen on the pins; saturates so a long hold never wraps
    always_ff @(posedge clk) begin
        if (sys_rst || !linkClkOe) begin
            inhibLen_r <= `PSM_CNT_ZERO;
        end else if (!linkDatOe && inhibLen_r != '1) begin
            inhibLen_r <= inhibLen_r + 20'h00001;
        end
    end
    inhibit_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(linkDatOe) && txState_r == PSM_REQUEST) |-> inhibLen_r > 20'(`PSM_LINK_PER_CYC))
        else $error("inhibit shorter than a link period");

    // Start bit is low when the released clock rises
    start_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
        (riseW && txState_r == PSM_SHIFT && txBit_r == 4'h0) |-> linkDatOe)
        else $error("start bit not low at clock release");

    cmd_take_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmdReady |-> txState_r == PSM_INHIBIT && linkClkOe && $past(txState_r) == PSM_IDLE)
        else $error("command taken outside idle");

    pkt_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pktValid && !pktReady) |=> pktValid && $stable(pktByte0) && $stable(pktByte1)
            && $stable(pktByte2) && $stable(pktErr))
        else $error("packet changed before taken");

    buf_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (rxCnt_r == `PSM_FRAME_BITS && !bufReady) |=> rxCnt_r inside {`PSM_FRAME_BITS, 6'h00})
        else $error("waiting packet overrun");
endmodule

// file: rtl/psm_defs.svh
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH

// Frame layout
`define PSM_FRAME_BITS    6'd33
`define PSM_CHAR_BITS     11
`define PSM_PKT_BITS      33
`define PSM_TX_BITS       4'd11
`define PSM_PAR_IDX       4'd9
// Inhibit hold: longer than one link clock period (125 ns link, margin)
`define PSM_INHIBIT_NS    200000
`define PSM_CLK_NS        5
`define PSM_INHIBIT_CYC   (`PSM_INHIBIT_NS / `PSM_CLK_NS)
// One link clock period, the floor that any inhibit must exceed
`define PSM_LINK_PER_NS   125
`define PSM_LINK_PER_CYC  (`PSM_LINK_PER_NS / `PSM_CLK_NS)
// Request hold with data low before clock release
`define PSM_REQ_NS        1000
`define PSM_REQ_CYC       (`PSM_REQ_NS / `PSM_CLK_NS)
// Receive watchdog: a frame stalled this long is dropped
`define PSM_RXTO_NS       2000000
`define PSM_RXTO_CYC      (`PSM_RXTO_NS / `PSM_CLK_NS)
`define PSM_CNT_ZERO      20'h00000

`endif

// file: rtl/psm_pkg.sv
package psm_pkg;
    typedef enum logic [2:0] {
        PSM_IDLE    = 3'b000,
        PSM_INHIBIT = 3'b001,
        PSM_REQUEST = 3'b011,
        PSM_SHIFT   = 3'b010,
        PSM_RELEASE = 3'b110,
        PSM_ACK     = 3'b111
    } psm_tx_state_t;
    typedef logic [7:0] psm_byte_t;
endpackage

// file: rtl/psm_skid_buf.sv
// Two-entry buffer with valid/ready on both sides
module psm_skid_buf #(
    parameter int WIDTH = 25
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Drain side
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    logic [WIDTH-1:0] mem0_r;
    logic [WIDTH-1:0] mem1_r;
    logic [1:0]       count_r;
    logic             pushW;
    logic             popW;

    assign pushW = inValid && inReady;
    assign popW  = outValid && outReady;

    // Occupancy; ready reflects true space so back-pressure reaches source
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_r  <= 2'h0;
            inReady  <= 1'b1;
            outValid <= 1'b0;
        end else begin
            case ({pushW, popW})
                2'b10: count_r <= count_r + 2'h1;
                2'b01: count_r <= count_r - 2'h1;
                default: count_r <= count_r;
            endcase
            inReady  <= (count_r - {1'b0, popW} + {1'b0, pushW}) != 2'h2;
            outValid <= (count_r - {1'b0, popW} + {1'b0, pushW}) != 2'h0;
        end
    end

    // Entry 0 is head; registered output
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem0_r <= '0;
            mem1_r <= '0;
        end else begin
            if (popW) begin
                mem0_r <= (count_r == 2'h2) ? mem1_r : inData;
            end else if (pushW && count_r == 2'h0) begin
                mem0_r <= inData;
            end
            if (pushW && ((count_r == 2'h1 && !popW) || (count_r == 2'h2))) begin
                mem1_r <= inData;
            end
        end
    end
    assign outData = mem0_r;
endmodule

// file: tb/psm_mouse_model.sv
// Behavioural mouse: owns every link clock pulse, pulls lines low only
module psm_mouse_model (
    // Resolved link lines
    input  wire logic linkClk,
    input  wire logic linkDat,
    // Open-drain pulls, high pulls the line low
    output logic      mClkLow,
    output logic      mDatLow
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam realtime HALF = 62.5;

    // Reports stay off until an acknowledged command enables them
    bit streamOn = 1'b0;

    // Both lines released at power-up, nothing sent until commanded
    initial begin
        mClkLow = 1'b0;
        mDatLow = 1'b0;
    end

    // Data changes only while clock is high, host samples on the fall
    task automatic sendBits(input logic [32:0] bits, input int n);
        wait (streamOn);
        for (int i = 0; i < n; i++) begin
            mDatLow = ~bits[i];
            #(HALF) mClkLow = 1'b1;
            #(HALF) mClkLow = 1'b0;
        end
        mDatLow = 1'b0;
        #(4*HALF);
    endtask

    // Waits for inhibit then request, clocks 12 bits, samples on the first 10 rises
    task automatic recvCmd(input bit doAck, input realtime lag, output logic [9:0] got);
        wait (linkClk === 1'b0);
        wait (linkDat === 1'b0);
        wait (linkClk === 1'b1);
        #(lag);
        for (int i = 0; i < 12; i++) begin
            if (i >= 10) begin
                mDatLow = doAck;
            end
            #(HALF) mClkLow = 1'b1;
            #(HALF) mClkLow = 1'b0;
            if (i < 10) begin
                got[i] = linkDat;
            end
        end
        mDatLow = 1'b0;
        if (doAck) begin
            streamOn = 1'b1;
        end
        #(4*HALF);
    endtask
endmodule

// file: tb/psm_mouse_host_bench.sv
module psm_mouse_host_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import psm_pkg::*;

    logic      clk       = 1'b0;
    logic      sys_rst   = 1'b1;
    psm_byte_t cmdByte   = 8'h00;
    logic      cmdValid  = 1'b0;
    logic      pktReady  = 1'b0;
    logic      linkClkOut, linkClkOe, linkDatOut, linkDatOe, mClkLow, mDatLow;
    logic      cmdReady, txDone, txAckOk, pktErr, pktValid;
    psm_byte_t pktByte0, pktByte1, pktByte2;
    int        n_mismatch = 0;
    int        n_compared = 0;

    // Pull-ups on both lines; any party may pull low
    wire logic linkClk = (linkClkOe ? linkClkOut : 1'b1) & ~mClkLow;
    wire logic linkDat = (linkDatOe ? linkDatOut : 1'b1) & ~mDatLow;

    always #2.5 clk = ~clk;

    psm_mouse_host #(.INHIBIT_CYC(40), .RXTO_CYC(400)) DUT (
        .clk(clk), .sys_rst(sys_rst),
        .linkClkIn(linkClk), .linkClkOut(linkClkOut), .linkClkOe(linkClkOe),
        .linkDatIn(linkDat), .linkDatOut(linkDatOut), .linkDatOe(linkDatOe),
        .cmdByte(cmdByte), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .txDone(txDone), .txAckOk(txAckOk),
        .pktByte0(pktByte0), .pktByte1(pktByte1), .pktByte2(pktByte2),
        .pktErr(pktErr), .pktValid(pktValid), .pktReady(pktReady)
    );

    psm_mouse_model mouse (
        .linkClk(linkClk), .linkDat(linkDat), .mClkLow(mClkLow), .mDatLow(mDatLow)
    );

    task automatic chk(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Start zero, data LSB first, odd parity (optionally broken), stop one
    function automatic logic [10:0] frame(input psm_byte_t b, input bit badPar);
        return {1'b1, ~^b ^ badPar, b, 1'b0};
    endfunction

    task automatic sendPkt(input psm_byte_t b0, b1, b2, input bit bad);
        mouse.sendBits({frame(b2, 1'b0), frame(b1, bad), frame(b0, 1'b0)}, 33);
    endtask

    // Takes one packet, raising ready at the next negedge and holding it until one cycle after pktValid is seen
    task automatic getPkt(input psm_byte_t e0, e1, e2, input logic eErr);
        int n = 0;
        @(negedge clk);
        pktReady = 1'b1;
        while (pktValid !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(pktValid === 1'b1, "packet ready");
        chk({pktErr, pktByte2, pktByte1, pktByte0} === {eErr, e2, e1, e0}, "packet");
        @(negedge clk);
        pktReady = 1'b0;
    endtask

    // One command byte; inhibit, request and shifted frame are all watched
    task automatic txCmd(input psm_byte_t b, input bit doAck, input realtime lag);
        logic [9:0] got;
        realtime    t0;
        int         n = 0;
        @(negedge clk);
        cmdByte = b;
        cmdValid = 1'b1;
        fork
            mouse.recvCmd(doAck, lag, got);
            begin
                @(posedge linkClkOe) t0 = $realtime;
                @(posedge linkDatOe);
                chk(linkClkOe === 1'b1 && $realtime - t0 > 125.0, "inhibit");
                @(negedge linkClkOe);
                chk(linkDatOe === 1'b1, "request");
            end
            begin
                while (cmdReady !== 1'b1 && n < 10) begin
                    @(negedge clk);
                    n++;
                end
                cmdValid = 1'b0;
                n = 0;
                while (txDone !== 1'b1 && n < 20000) begin
                    @(negedge clk);
                    n++;
                end
                chk(txDone === 1'b1 && txAckOk === doAck, "send result");
            end
        join
        chk(got === {1'b1, ~^b, b}, "sent frame");
    endtask

    task automatic rxGood;
        sendPkt(8'h09, 8'h5a, 8'hc3, 1'b0);
        getPkt(8'h09, 8'h5a, 8'hc3, 1'b0);
    endtask

    task automatic rxParity;
        sendPkt(8'h18, 8'hff, 8'h00, 1'b1);
        getPkt(8'h18, 8'hff, 8'h00, 1'b1);
    endtask

    // Receiver stalls: two entries fill, third waits in the shifter
    task automatic rxFill;
        sendPkt(8'h01, 8'h02, 8'h03, 1'b0);
        sendPkt(8'h80, 8'h40, 8'h20, 1'b0);
        sendPkt(8'haa, 8'h55, 8'h7e, 1'b0);
        getPkt(8'h01, 8'h02, 8'h03, 1'b0);
        getPkt(8'h80, 8'h40, 8'h20, 1'b0);
        getPkt(8'haa, 8'h55, 8'h7e, 1'b0);
    endtask

    // Frame cut after 20 bits must be dropped before the next packet lands
    task automatic rxCut;
        mouse.sendBits({11'h000, frame(8'h66, 1'b0), frame(8'h99, 1'b0)}, 20);
        #3000;
        sendPkt(8'h3c, 8'h0f, 8'hf0, 1'b0);
        getPkt(8'h3c, 8'h0f, 8'hf0, 1'b0);
    endtask

    // Enabling command first: the mouse reports nothing before it
    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        chk(linkClkOe === 1'b0 && linkDatOe === 1'b0 && pktValid === 1'b0, "reset");
        txCmd(8'hf4, 1'b1, 500.0);
        rxGood();
        rxParity();
        txCmd(8'h00, 1'b0, 5000.0);
        @(negedge clk);
        rxCut();
        rxFill();
        final_report();
    end

    // Whole run takes well under 100 us
    initial begin
        #400000;
        n_mismatch++;
        final_report();
    end
endmodule
